// [svm_filt.sv]
module svm_filt (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic resetn,
  // Sampling strobe and level
  input  wire logic sample,
  input  wire logic din,
  output logic      dout
);
  typedef struct packed {
    logic [2:0] sh;
    logic       out;
  } svm_filt_st_t;

  svm_filt_st_t q;
  svm_filt_st_t d;

  // A level is taken only once three samples agree, so short glitches die
  always_comb begin
    d = q;
    if (sample) begin
      d.sh = {q.sh[1:0], din};
      if (d.sh == 3'h7) begin
        d.out = 1'b1;
      end else if (d.sh == 3'h0) begin
        d.out = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      q <= {svm_pkg::FILT_RST, 1'b1};
    end else begin
      q <= d;
    end
  end

  assign dout = q.out;
endmodule // svm_filt

// [svm_pkg.sv]
package svm_pkg;

  // Clock and timing
  localparam int CLK_HZ             = 250_000_000;
  localparam int OSC_HZ             = 125_000;
  localparam int OSC_DIV            = CLK_HZ / OSC_HZ;
  localparam int DETECTOR_SETTLE_US = 100;
  localparam int SETTLE_CYC_DEF     = DETECTOR_SETTLE_US * (CLK_HZ / 1_000_000);
  localparam int OPT_SYNC_CYC       = 2;

  // Option byte location and field
  localparam logic [15:0] OPTION_BYTE_ADDR = 16'hFFFF;
  localparam int          OPT_MON0_BIT     = 5;

  // Register byte addresses
  localparam logic [7:0] ADDR_DETCTL  = 8'h00;
  localparam logic [7:0] ADDR_MON0    = 8'h04;
  localparam logic [7:0] ADDR_COMMON  = 8'h08;
  localparam logic [7:0] ADDR_LEVEL   = 8'h0C;
  localparam logic [7:0] ADDR_MON1    = 8'h10;
  localparam logic [7:0] ADDR_CLKMODE = 8'h14;
  localparam logic [7:0] ADDR_OPTION  = 8'h18;
  localparam logic [7:0] ADDR_IRQ_ST  = 8'h1C;
  localparam logic [7:0] ADDR_IRQ_MSK = 8'h20;

  // Field positions
  localparam int DET0_BIT      = 0;
  localparam int DET1_BIT      = 1;
  localparam int SET0_BIT      = 4;
  localparam int SET1_BIT      = 5;
  localparam int M1_EN_BIT     = 0;
  localparam int M1_FDIS_BIT   = 1;
  localparam int M1_FLAG_BIT   = 2;
  localparam int M1_FSEL_LSB   = 4;
  localparam int M1_MODE_BIT   = 6;
  localparam int M1_EDGE_BIT   = 7;
  localparam int IRQ_M1_BIT    = 0;
  localparam int IRQ_M0_BIT    = 1;

  // Reset values
  localparam logic       OSC_STOP_RST = 1'h1;
  localparam logic       M1_FDIS_RST  = 1'h1;
  localparam logic [2:0] FILT_RST     = 3'h7;
  localparam logic [1:0] IRQ_MSK_RST  = 2'h0;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic        awvalid;
    logic [7:0]  awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [7:0]  araddr;
    logic        rready;
  } svm_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } svm_axi_rsp_t;

endpackage

// [svm_sync.sv]
module svm_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         resetn,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_q;

  // Two stages; only the second stage is read outside
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule // svm_sync

// [svm_top.sv]
// What this block does
// R1: Option bit selects monitor 0 reset after reset
// R2: Option byte sits at fixed address
// R3: Enable detector 0, settle, then arm reset
// R4: Monitor 0 reset enable allows supply reset
// R5: Common enable gates monitors 1 and 2; only monitor 1 exists here and is gated
// R6: Four-bit field selects monitor 1 threshold
// R7: Enable detector 1, settle before filter/mode
// R8: Two-bit field picks filter sampling division
// R9: Unfiltered, timing bit picks crossing direction
// R10: Filter disable bit: 0 filters, 1 bypasses
// R11: Mode bit: 0 interrupt, 1 reset
// R12: Writing 0 clears the passage flag
// R13: Oscillator stop bit 0 runs filter clock
// R14: Software waits three samples before enabling
// R15: Monitor 1 enable arms selected response
// R16: Flag sets on crossing even before arming
// R17: Reset use unfiltered sets timing bit one
// R18: Config frozen while monitor 1 enabled
// R19: Filter needs stable consecutive samples
//
// Added by the designer: the AXI4-Lite register port.
module svm_top #(
  parameter int SETTLE_CYC = svm_pkg::SETTLE_CYC_DEF
) (
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  resetn,
  // Register bus
  input  wire svm_pkg::svm_axi_req_t axi_req,
  output svm_pkg::svm_axi_rsp_t      axi_rsp,
  // Option byte and comparators
  input  wire logic [7:0]            option_select_byte,
  input  wire logic                  mon0_cmp_below,
  input  wire logic                  mon1_cmp_above,
  // Analog controls
  output logic                       detector0_on,
  output logic                       detector1_on,
  output logic [3:0]                 mon1_level_select,
  output logic                       lowspeed_osc_run,
  // Responses
  output logic                       mon0_reset_req,
  output logic                       mon1_reset_req,
  output logic                       irq
);
  typedef struct packed {
    logic [1:0]  opt_cnt;
    logic        opt_done;
    logic [7:0]  opt_byte;
    logic        det0_en;
    logic        det1_en;
    logic [15:0] set0_cnt;
    logic [15:0] set1_cnt;
    logic        mon0_rst_en;
    logic        common_en;
    logic [3:0]  level;
    logic        m1_en;
    logic        m1_fdis;
    logic        m1_flag;
    logic [1:0]  m1_fsel;
    logic        m1_mode;
    logic        m1_edge;
    logic        osc_stop;
    logic [10:0] osc_cnt;
    logic [2:0]  smp_cnt;
    logic        lvl_prev;
    logic        m0_prev;
    logic        m0_rst;
    logic        m1_rst;
    logic [1:0]  irq_st;
    logic [1:0]  irq_msk;
    logic        aw_ok;
    logic [7:0]  aw_addr;
    logic        w_ok;
    logic [7:0]  w_data;
    logic        w_lane0;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } svm_top_st_t;

  svm_top_st_t q;
  svm_top_st_t d;

  logic [7:0] opt_s;
  logic       m0_below;
  logic       m1_raw;
  logic       m1_filt;
  logic       osc_tick;
  logic       smp_tick;
  logic       set0_done;
  logic       set1_done;
  logic       m1_active;
  logic       m1_lvl;
  logic       m1_cross;
  logic       m1_evt;
  logic       do_wr;

  // Settle counter step, shared by both detectors
  function automatic logic [15:0] settle_step(input logic en, input logic [15:0] cnt);
    if (!en) begin
      return 16'h0000;
    end
    return (cnt == 16'(SETTLE_CYC)) ? cnt : cnt + 16'h0001;
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    return a inside {svm_pkg::ADDR_DETCTL, svm_pkg::ADDR_MON0, svm_pkg::ADDR_COMMON,
                     svm_pkg::ADDR_LEVEL, svm_pkg::ADDR_MON1, svm_pkg::ADDR_CLKMODE,
                     svm_pkg::ADDR_OPTION, svm_pkg::ADDR_IRQ_ST, svm_pkg::ADDR_IRQ_MSK};
  endfunction

  // Pins from outside the clock domain
  svm_sync #(.W(10)) u_sync (
    .core_clk (core_clk),
    .resetn   (resetn),
    .din      ({option_select_byte, mon0_cmp_below, mon1_cmp_above}),
    .dout     ({opt_s, m0_below, m1_raw})
  );

  svm_filt u_filt (
    .core_clk (core_clk),
    .resetn   (resetn),
    .sample   (smp_tick),
    .din      (m1_raw),
    .dout     (m1_filt)
  );

  // Sampling clock: low-speed oscillator, then 1/2/4/8 division
  assign osc_tick  = !q.osc_stop && (q.osc_cnt == 11'(svm_pkg::OSC_DIV - 1)); // R13
  assign smp_tick  = osc_tick && ((q.smp_cnt & (3'(4'h1 << q.m1_fsel) - 3'h1)) == 3'h0); // R8
  assign set0_done = q.set0_cnt == 16'(SETTLE_CYC);
  assign set1_done = q.set1_cnt == 16'(SETTLE_CYC);

  // Monitor 1 watches only with the common and detector enables settled
  assign m1_active = q.common_en && q.det1_en && set1_done; // R5 R7
  assign m1_lvl    = q.m1_fdis ? m1_raw : m1_filt; // R10 R19
  assign m1_cross  = m1_active && (m1_lvl != q.lvl_prev);
  assign m1_evt    = m1_cross && (!q.m1_fdis || (q.m1_edge ? !m1_lvl : m1_lvl)); // R9 R17
  assign do_wr     = q.aw_ok && q.w_ok && !q.bvalid;

  // Next-state logic for everything the block holds
  always_comb begin
    d = q;
    // Option byte is caught once the strap has crossed the synchroniser
    if (!q.opt_done) begin
      if (q.opt_cnt == 2'(svm_pkg::OPT_SYNC_CYC)) begin
        d.opt_done    = 1'b1;
        d.opt_byte    = opt_s; // R2
        d.mon0_rst_en = opt_s[svm_pkg::OPT_MON0_BIT]; // R1
        d.det0_en     = opt_s[svm_pkg::OPT_MON0_BIT]; // R1
      end else begin
        d.opt_cnt = q.opt_cnt + 2'h1;
      end
    end
    d.set0_cnt = settle_step(q.det0_en, q.set0_cnt); // R3
    d.set1_cnt = settle_step(q.det1_en, q.set1_cnt); // R7
    // Oscillator divider stops with the stop bit, freezing the filter
    if (q.osc_stop) begin
      d.osc_cnt = 11'h000;
      d.smp_cnt = 3'h0;
    end else if (osc_tick) begin
      d.osc_cnt = 11'h000;
      d.smp_cnt = q.smp_cnt + 3'h1;
    end else begin
      d.osc_cnt = q.osc_cnt + 11'h001;
    end
    d.lvl_prev = m1_lvl;
    d.m0_prev  = m0_below;
    // Monitor 0 resets only once armed after its detector settled
    d.m0_rst = q.mon0_rst_en && set0_done && m0_below; // R3 R4
    // Reset response of monitor 1 is a one-cycle request
    d.m1_rst = m1_evt && q.m1_en && q.m1_mode; // R11 R15
    // Write channel: address and data may come in either order
    if (axi_req.awvalid && !q.aw_ok && !q.bvalid) begin
      d.aw_ok   = 1'b1;
      d.aw_addr = axi_req.awaddr;
    end
    if (axi_req.wvalid && !q.w_ok && !q.bvalid) begin
      d.w_ok    = 1'b1;
      d.w_data  = axi_req.wdata[7:0];
      d.w_lane0 = axi_req.wstrb[0];
    end
    if (q.bvalid && axi_req.bready) begin
      d.bvalid = 1'b0;
    end
    if (do_wr) begin
      d.aw_ok  = 1'b0;
      d.w_ok   = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = addr_ok(q.aw_addr) ? svm_pkg::RESP_OKAY : svm_pkg::RESP_SLVERR;
    end
    // Register writes; every field lives in byte lane 0
    if (do_wr && q.w_lane0) begin
      unique case (q.aw_addr)
        svm_pkg::ADDR_DETCTL: begin
          d.det0_en = q.w_data[svm_pkg::DET0_BIT]; // R3
          d.det1_en = q.w_data[svm_pkg::DET1_BIT]; // R7
        end
        svm_pkg::ADDR_MON0: begin
          d.mon0_rst_en = q.w_data[0]; // R4
        end
        svm_pkg::ADDR_COMMON: begin
          d.common_en = q.w_data[0]; // R5
        end
        svm_pkg::ADDR_LEVEL: begin
          // Threshold moves only while detector 1 is off
          if (!q.det1_en) begin
            d.level = q.w_data[3:0]; // R6
          end
        end
        svm_pkg::ADDR_MON1: begin
          d.m1_en = q.w_data[svm_pkg::M1_EN_BIT]; // R15
          // Filter, timing and mode only change while disarmed
          if (!q.m1_en) begin
            d.m1_fdis = q.w_data[svm_pkg::M1_FDIS_BIT]; // R10 R18
            d.m1_fsel = q.w_data[svm_pkg::M1_FSEL_LSB +: 2]; // R8 R18
            d.m1_mode = q.w_data[svm_pkg::M1_MODE_BIT]; // R11 R18
            d.m1_edge = q.w_data[svm_pkg::M1_EDGE_BIT]; // R9 R18
          end
          // Writing a one to the flag leaves it alone
          if (!q.w_data[svm_pkg::M1_FLAG_BIT]) begin
            d.m1_flag = 1'b0; // R12
          end
        end
        svm_pkg::ADDR_CLKMODE: begin
          d.osc_stop = q.w_data[0]; // R13
        end
        svm_pkg::ADDR_IRQ_ST: begin
          d.irq_st = q.irq_st & ~q.w_data[1:0];
        end
        svm_pkg::ADDR_IRQ_MSK: begin
          d.irq_msk = q.w_data[1:0];
        end
        default: begin
        end
      endcase
    end
    // Hardware sets come last so an event beats a same-cycle clear
    if (m1_evt) begin
      d.m1_flag = 1'b1; // R16
    end
    if (m1_evt && q.m1_en && !q.m1_mode) begin
      d.irq_st[svm_pkg::IRQ_M1_BIT] = 1'b1; // R11 R15
    end
    if (q.det0_en && set0_done && m0_below && !q.m0_prev) begin
      d.irq_st[svm_pkg::IRQ_M0_BIT] = 1'b1;
    end
    // Read channel: answer one cycle after the address is taken
    if (q.rvalid && axi_req.rready) begin
      d.rvalid = 1'b0;
    end
    if (axi_req.arvalid && !q.rvalid) begin
      d.rvalid = 1'b1;
      d.rresp  = addr_ok(axi_req.araddr) ? svm_pkg::RESP_OKAY : svm_pkg::RESP_SLVERR;
      d.rdata  = 32'h0000_0000;
      unique case (axi_req.araddr)
        svm_pkg::ADDR_DETCTL: begin
          d.rdata[svm_pkg::DET0_BIT] = q.det0_en;
          d.rdata[svm_pkg::DET1_BIT] = q.det1_en;
          d.rdata[svm_pkg::SET0_BIT] = set0_done;
          d.rdata[svm_pkg::SET1_BIT] = set1_done;
        end
        svm_pkg::ADDR_MON0:    d.rdata[0] = q.mon0_rst_en;
        svm_pkg::ADDR_COMMON:  d.rdata[0] = q.common_en;
        svm_pkg::ADDR_LEVEL:   d.rdata[3:0] = q.level;
        svm_pkg::ADDR_MON1:    d.rdata[7:0] = {q.m1_edge, q.m1_mode, q.m1_fsel, 1'b0,
                                               q.m1_flag, q.m1_fdis, q.m1_en};
        svm_pkg::ADDR_CLKMODE: d.rdata[0] = q.osc_stop;
        svm_pkg::ADDR_OPTION:  d.rdata[7:0] = q.opt_byte; // R2
        svm_pkg::ADDR_IRQ_ST:  d.rdata[1:0] = q.irq_st;
        svm_pkg::ADDR_IRQ_MSK: d.rdata[1:0] = q.irq_msk;
        default: begin
        end
      endcase
    end
  end

  // All state registered together
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      q          <= '0;
      q.m1_fdis  <= svm_pkg::M1_FDIS_RST;
      q.osc_stop <= svm_pkg::OSC_STOP_RST;
      q.irq_msk  <= svm_pkg::IRQ_MSK_RST;
      q.lvl_prev <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Bus handshakes are combinational from held state
  always_comb begin
    axi_rsp         = '0;
    axi_rsp.awready = !q.aw_ok && !q.bvalid;
    axi_rsp.wready  = !q.w_ok && !q.bvalid;
    axi_rsp.bvalid  = q.bvalid;
    axi_rsp.bresp   = q.bresp;
    axi_rsp.arready = !q.rvalid;
    axi_rsp.rvalid  = q.rvalid;
    axi_rsp.rdata   = q.rdata;
    axi_rsp.rresp   = q.rresp;
  end

  assign detector0_on      = q.det0_en;
  assign detector1_on      = q.det1_en;
  assign mon1_level_select = q.level;
  assign lowspeed_osc_run  = !q.osc_stop;
  assign mon0_reset_req    = q.m0_rst;
  assign mon1_reset_req    = q.m1_rst;
  assign irq               = |(q.irq_st & q.irq_msk);

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  opt_capture_a: assert property ($rose(q.opt_done) |-> // R1
      q.mon0_rst_en == $past(opt_s[svm_pkg::OPT_MON0_BIT]))
    else $error("option bit not applied to monitor 0");
  mon0_gate_a: assert property (mon0_reset_req |-> // R3 R4
      $past(q.mon0_rst_en) && $past(set0_done) && $past(m0_below))
    else $error("monitor 0 reset without arming or settle");
  common_gate_a: assert property (mon1_reset_req |-> // R5
      $past(q.common_en) && $past(q.det1_en) && $past(q.m1_en))
    else $error("monitor 1 reset while not enabled");
  cfg_static_a: assert property (q.m1_en && $past(q.m1_en) |-> // R18
      $stable({q.m1_fdis, q.m1_fsel, q.m1_mode, q.m1_edge}))
    else $error("monitor 1 config moved while armed");
  flag_clear_a: assert property (do_wr && q.w_lane0 && q.aw_addr == svm_pkg::ADDR_MON1 // R12
      && !q.w_data[svm_pkg::M1_FLAG_BIT] && !m1_evt |=> !q.m1_flag)
    else $error("passage flag not cleared by zero");
  // A software clear may follow the set at once, so only the set edge is checked
  flag_set_a: assert property (m1_evt |=> q.m1_flag) // R16
    else $error("passage flag missed a crossing");
  irq_mode_a: assert property ($rose(q.irq_st[svm_pkg::IRQ_M1_BIT]) |-> // R11 R15
      $past(!q.m1_mode && q.m1_en))
    else $error("interrupt raised in reset mode");
  edge_sel_a: assert property (m1_evt && q.m1_fdis |-> m1_lvl == !q.m1_edge) // R9
    else $error("crossing in unselected direction");
  // Filter holds still while its sampling clock is stopped
  sequence filt_frozen_s;
    !smp_tick ##1 $stable(m1_filt);
  endsequence
  osc_stop_a: assert property (q.osc_stop |-> filt_frozen_s) // R13
    else $error("filter sampled with oscillator stopped");
  filt_hold_a: assert property ($changed(m1_filt) |-> $past(smp_tick)) // R19
    else $error("filter output moved without a sample");
endmodule // svm_top

// [svm_top_bench.sv]
module svm_top_bench;
  timeunit 1ns;
  timeprecision 1ps;

  // Short settle count keeps the run brief; expectations derive from it
  localparam int SETTLE = 8;
  localparam int TICK   = 2000;

  logic                  core_clk;
  logic                  resetn;
  svm_pkg::svm_axi_req_t req;
  svm_pkg::svm_axi_rsp_t rsp;
  logic [7:0]            opt_v;
  logic                  cmp0;
  logic                  cmp1;
  logic                  detector0_on;
  logic                  detector1_on;
  logic [3:0]            mon1_level_select;
  logic                  lowspeed_osc_run;
  logic                  mon0_reset_req;
  logic                  mon1_reset_req;
  logic                  irq;
  logic [3:0]            lvl;
  logic [7:0]            ua;
  int                    n_errors = 0;
  int                    check_count = 0;
  int                    m1_pulses = 0;
  int                    n;
  int                    p;

  svm_top #(.SETTLE_CYC(SETTLE)) svm_top_i (
    .core_clk           (core_clk),
    .resetn             (resetn),
    .axi_req            (req),
    .axi_rsp            (rsp),
    .option_select_byte (opt_v),
    .mon0_cmp_below     (cmp0),
    .mon1_cmp_above     (cmp1),
    .detector0_on       (detector0_on),
    .detector1_on       (detector1_on),
    .mon1_level_select  (mon1_level_select),
    .lowspeed_osc_run   (lowspeed_osc_run),
    .mon0_reset_req     (mon0_reset_req),
    .mon1_reset_req     (mon1_reset_req),
    .irq                (irq)
  );

  initial core_clk = 1'b0;
  always #2 core_clk = ~core_clk;

  // Counts reset request cycles, so a stretched pulse shows up as a surplus
  always @(posedge core_clk) begin
    if (mon1_reset_req === 1'b1) begin
      m1_pulses <= m1_pulses + 1;
    end
  end

  // Expected monitor 1 control word
  function automatic logic [31:0] m1(input int en, fd, fl, fs, md, ed);
    return 32'((en << svm_pkg::M1_EN_BIT) | (fd << svm_pkg::M1_FDIS_BIT) |
               (fl << svm_pkg::M1_FLAG_BIT) | (fs << svm_pkg::M1_FSEL_LSB) |
               (md << svm_pkg::M1_MODE_BIT) | (ed << svm_pkg::M1_EDGE_BIT));
  endfunction

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge core_clk);
  endtask

  // Write with both channels offered together, each released when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    bit aw_d;
    bit w_d;
    logic [1:0] resp;
    aw_d = 0;
    w_d = 0;
    resp = 2'h3;
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= s;
    req.bready <= 1'b1;
    repeat (64) begin
      @(posedge core_clk);
      if (!aw_d && rsp.awready) begin
        aw_d = 1;
        req.awvalid <= 1'b0;
      end
      if (!w_d && rsp.wready) begin
        w_d = 1;
        req.wvalid <= 1'b0;
      end
      if (rsp.bvalid) begin
        resp = rsp.bresp;
        break;
      end
    end
    req.bready <= 1'b0;
    @(posedge core_clk);
    chk("bresp", 32'(er), 32'(resp));
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    bit ar_d;
    logic [31:0] dat;
    logic [1:0] resp;
    ar_d = 0;
    dat = 32'hFFFF_FFFF;
    resp = 2'h3;
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    repeat (64) begin
      @(posedge core_clk);
      if (!ar_d && rsp.arready) begin
        ar_d = 1;
        req.arvalid <= 1'b0;
      end
      if (rsp.rvalid) begin
        dat = rsp.rdata;
        resp = rsp.rresp;
        break;
      end
    end
    req.rready <= 1'b0;
    @(posedge core_clk);
    chk("rdata", exp, dat);
    chk("rresp", 32'(er), 32'(resp));
  endtask

  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Filter waits need about 60k cycles at most; half again as margin
  initial begin
    cyc(90000);
    n_errors++;
    report_and_stop();
  end

  initial begin
    void'($urandom(32'h90ED));
    req = '0;
    resetn = 1'b0;
    cmp0 = 1'b0;
    cmp1 = 1'b1;
    opt_v = 8'($urandom()) | 8'h20;
    lvl = 4'($urandom());
    ua = 8'h24 + 8'(4 * ($urandom() % 55));
    cyc(10);
    chk("rst_outs", 0, {mon0_reset_req, mon1_reset_req, irq, detector1_on, rsp.bvalid});
    resetn <= 1'b1;
    cyc(6);
    chk("det0_opt", 1, 32'(detector0_on));
    rd(svm_pkg::ADDR_MON0, 1, svm_pkg::RESP_OKAY);
    rd(svm_pkg::ADDR_OPTION, 32'(opt_v), svm_pkg::RESP_OKAY);
    rd(svm_pkg::ADDR_MON1, m1(0, 1, 0, 0, 0, 0), svm_pkg::RESP_OKAY);
    rd(svm_pkg::ADDR_CLKMODE, 1, svm_pkg::RESP_OKAY);
    rd(svm_pkg::ADDR_COMMON, 0, svm_pkg::RESP_OKAY);
    rd(svm_pkg::ADDR_IRQ_MSK, 0, svm_pkg::RESP_OKAY);
    rd(ua, 0, svm_pkg::RESP_SLVERR);
    wr(ua, $urandom(), 4'hF, svm_pkg::RESP_SLVERR);
    wr(svm_pkg::ADDR_IRQ_MSK, 3, 4'hE, svm_pkg::RESP_OKAY);
    rd(svm_pkg::ADDR_IRQ_MSK, 0, svm_pkg::RESP_OKAY);
    // Monitor 0: no reset while the detector is switched off
    wr(svm_pkg::ADDR_DETCTL, 0, 4'hF, svm_pkg::RESP_OKAY);
    cmp0 <= 1'b1;
    cyc(20);
    chk("mon0_off", 0, 32'(mon0_reset_req));
    // Supply recovers so the settled detector later sees a fresh drop
    cmp0 <= 1'b0;
    wr(svm_pkg::ADDR_MON0, 0, 4'hF, svm_pkg::RESP_OKAY);
    wr(svm_pkg::ADDR_DETCTL, 1, 4'hF, svm_pkg::RESP_OKAY);
    rd(svm_pkg::ADDR_DETCTL, 1, svm_pkg::RESP_OKAY);
    cyc(SETTLE + 5);
    rd(svm_pkg::ADDR_DETCTL, 32'h11, svm_pkg::RESP_OKAY);
    cmp0 <= 1'b1;
    cyc(5);
    chk("mon0_disarm", 0, 32'(mon0_reset_req));
    wr(svm_pkg::ADDR_MON0, 1, 4'hF, svm_pkg::RESP_OKAY);
    chk("mon0_req", 1, 32'(mon0_reset_req));
    chk("irq_masked", 0, 32'(irq));
    wr(svm_pkg::ADDR_IRQ_MSK, 2, 4'hF, svm_pkg::RESP_OKAY);
    chk("irq_m0", 1, 32'(irq));
    cmp0 <= 1'b0;
    cyc(5);
    chk("mon0_rel", 0, 32'(mon0_reset_req));
    wr(svm_pkg::ADDR_IRQ_ST, 2, 4'hF, svm_pkg::RESP_OKAY);
    rd(svm_pkg::ADDR_IRQ_ST, 0, svm_pkg::RESP_OKAY);
    chk("irq_clr", 0, 32'(irq));
    wr(svm_pkg::ADDR_IRQ_MSK, 1, 4'hF, svm_pkg::RESP_OKAY);
    // Monitor 1 setup sequence, unfiltered
    wr(svm_pkg::ADDR_COMMON, 1, 4'hF, svm_pkg::RESP_OKAY);
    wr(svm_pkg::ADDR_LEVEL, 32'(lvl), 4'hF, svm_pkg::RESP_OKAY);
    chk("level", 32'(lvl), 32'(mon1_level_select));
    wr(svm_pkg::ADDR_DETCTL, 3, 4'hF, svm_pkg::RESP_OKAY);
    chk("det1_on", 1, 32'(detector1_on));
    cyc(SETTLE + 5);
    wr(svm_pkg::ADDR_LEVEL, 32'(~lvl), 4'hF, svm_pkg::RESP_OKAY);
    chk("level_hold", 32'(lvl), 32'(mon1_level_select));
    wr(svm_pkg::ADDR_MON1, m1(0, 1, 0, 0, 0, 1), 4'hF, svm_pkg::RESP_OKAY);
    cmp1 <= 1'b0;
    cyc(8);
    rd(svm_pkg::ADDR_MON1, m1(0, 1, 1, 0, 0, 1), svm_pkg::RESP_OKAY);
    rd(svm_pkg::ADDR_IRQ_ST, 0, svm_pkg::RESP_OKAY);
    wr(svm_pkg::ADDR_MON1, m1(0, 1, 0, 0, 0, 1), 4'hF, svm_pkg::RESP_OKAY);
    rd(svm_pkg::ADDR_MON1, m1(0, 1, 0, 0, 0, 1), svm_pkg::RESP_OKAY);
    cmp1 <= 1'b1;
    cyc(8);
    rd(svm_pkg::ADDR_MON1, m1(0, 1, 0, 0, 0, 1), svm_pkg::RESP_OKAY);
    wr(svm_pkg::ADDR_MON1, m1(1, 1, 0, 0, 0, 1), 4'hF, svm_pkg::RESP_OKAY);
    cmp1 <= 1'b0;
    cyc(8);
    chk("irq_m1", 1, 32'(irq));
    rd(svm_pkg::ADDR_IRQ_ST, 1, svm_pkg::RESP_OKAY);
    wr(svm_pkg::ADDR_MON1, m1(1, 0, 1, 1, 1, 0), 4'hF, svm_pkg::RESP_OKAY);
    rd(svm_pkg::ADDR_MON1, m1(1, 1, 1, 0, 0, 1), svm_pkg::RESP_OKAY);
    wr(svm_pkg::ADDR_IRQ_ST, 1, 4'hF, svm_pkg::RESP_OKAY);
    chk("irq_m1_clr", 0, 32'(irq));
    chk("no_pulse", 0, 32'(m1_pulses));
    wr(svm_pkg::ADDR_MON1, m1(0, 1, 0, 0, 0, 1), 4'hF, svm_pkg::RESP_OKAY);
    wr(svm_pkg::ADDR_MON1, m1(0, 1, 0, 0, 0, 0), 4'hF, svm_pkg::RESP_OKAY);
    cmp1 <= 1'b1;
    cyc(8);
    rd(svm_pkg::ADDR_MON1, m1(0, 1, 1, 0, 0, 0), svm_pkg::RESP_OKAY);
    wr(svm_pkg::ADDR_MON1, m1(0, 1, 0, 0, 1, 1), 4'hF, svm_pkg::RESP_OKAY);
    wr(svm_pkg::ADDR_MON1, m1(1, 1, 0, 0, 1, 1), 4'hF, svm_pkg::RESP_OKAY);
    cmp1 <= 1'b0;
    cyc(8);
    chk("rst_pulse", 1, 32'(m1_pulses));
    wr(svm_pkg::ADDR_MON1, m1(0, 1, 0, 0, 1, 1), 4'hF, svm_pkg::RESP_OKAY);
    // Filtered path: oscillator on, then timing at sampling divisions 1 and 2
    wr(svm_pkg::ADDR_CLKMODE, 0, 4'hF, svm_pkg::RESP_OKAY);
    chk("osc_run", 1, 32'(lowspeed_osc_run));
    for (int fs = 0; fs < 2; fs++) begin
      p = TICK << fs;
      wr(svm_pkg::ADDR_MON1, m1(0, 0, 0, fs, 0, 0), 4'hF, svm_pkg::RESP_OKAY);
      wr(svm_pkg::ADDR_MON1, m1(1, 0, 0, fs, 0, 0), 4'hF, svm_pkg::RESP_OKAY);
      cyc(4 * p);
      wr(svm_pkg::ADDR_IRQ_ST, 1, 4'hF, svm_pkg::RESP_OKAY);
      if (fs == 0) begin
        cmp1 <= ~cmp1;
        @(posedge core_clk);
        cmp1 <= ~cmp1;
        cyc(4 * p);
        chk("glitch", 0, 32'(irq));
      end
      cmp1 <= ~cmp1;
      n = 0;
      while (irq !== 1'b1 && n < 4 * p) begin
        @(posedge core_clk);
        n++;
      end
      chk("filt_delay", 1, 32'(n >= 2 * p && n <= 3 * p + 20));
      wr(svm_pkg::ADDR_IRQ_ST, 1, 4'hF, svm_pkg::RESP_OKAY);
      wr(svm_pkg::ADDR_MON1, m1(0, 0, 0, fs, 0, 0), 4'hF, svm_pkg::RESP_OKAY);
    end
    report_and_stop();
  end
endmodule // svm_top_bench
